// *** src/piv_consts.svh ***
// Functional notes
// R1: Eight request latch bits; each source sets only its own bit.
// R2: A command bit picks the fifth timer or parallel bit seven as source eight.
// R3: Select bit 0 feeds parallel input bit seven; 1 feeds the fifth timer.
// R4: The controller-reset command bit clears all request latches in parallel.
// R5: Controller reset keeps transmit-empty requesting; reset bit then self-clears.
// R6: Each vector read clears only the latch of the currently encoded source.
// R7: Driving the vector in an acknowledge cycle also clears that request.
// R8: Receive-ready and transmit-empty latches read as status regardless of mask.
// R9: Latches are ANDed with mask bits, 1 enables; only results feed encoder.
// R10: Mask D0 is first timer, D7 the eighth source; 0 masks but keeps latched.
// R11: Pending flag is the OR of masked requests; status bit and interrupt pin.
// R12: First timer is level 0, highest; eighth source is level 7, lowest.
// R13: Levels 1 to 6 follow mask bit order.
// R14: Encoder gives a three-bit level code of the highest active input.
// R15: With no active input the level is 7, all ones.
// R16: Vector byte holds level in bits 5..3, all other bits one.
// R17: Drivers enable for a read at address 0303H with input status and strobe.
// R18: Acknowledge drives the vector only when the acknowledge-enable bit is 1.
// R19: Pending returns to 0 only once all unmasked requests are cleared.
// R20: Fixed-call mode: processor calls 0038H without acknowledge status.
// R21: Table mode: processor issues acknowledge, then reads one pointer byte.
// R22: Processor forms table address from page register and pointer, D0 forced 0.
// R23: Processor clears its vector page register on reset or power-on clear.
// R24: Processor services while halted; hold overrides; low ready delays it.
`ifndef PIV_CONSTS_SVH
`define PIV_CONSTS_SVH

// ----------------------------------------------------------------------
// Port addresses and register fields
// ----------------------------------------------------------------------
`define PIV_PORT_STATUS   8'h00
`define PIV_PORT_COMMAND  8'h02
`define PIV_PORT_MASK     8'h03
`define PIV_PORT_VECTOR   16'h0303
`define PIV_CMD_RESET_BIT 0
`define PIV_CMD_SEL_BIT   2
`define PIV_CMD_ACK_BIT   3
`define PIV_STS_PEND_BIT  0
`define PIV_STS_RX_BIT    6
`define PIV_STS_TX_BIT    7
`define PIV_SRC_RX        4
`define PIV_SRC_TX        5
`define PIV_CMD_RESET_VAL 8'h00
`define PIV_MASK_RESET_VAL 8'h00
`define PIV_TX_ONLY       8'h20
`define PIV_IDLE_LEVEL    3'h7
`define PIV_VEC_HI        2'h3
`define PIV_VEC_LO        3'h7

`endif

// *** src/piv_pkg.sv ***
`default_nettype none

package piv_pkg;

  // Processor-side bus strobes and data, sampled on the core clock.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        s_inp;
    logic        s_out;
    logic        s_inta;
    logic        p_dbin;
    logic        p_wr_n;
  } piv_bus_t;

  // Request events from the nine possible sources, one-cycle pulses.
  typedef struct packed {
    logic [4:0] timer_zero;
    logic       ext_req;
    logic       receive_ready;
    logic       transmit_empty;
    logic       parallel_input_bit7;
  } piv_src_t;

endpackage : piv_pkg

`default_nettype wire

// *** src/piv_req_latch.sv ***
`default_nettype none

// ----------------------------------------------------------------------
// One request latch bit
// ----------------------------------------------------------------------
module piv_req_latch (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_q
);
  logic q_reg;
  logic q_next;

  // A set in the clearing cycle wins so that no request is ever lost.
  always_comb
  begin
    q_next = q_reg;
    if (i_set)
      q_next = 1'b1;
    else if (i_clr)
      q_next = 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q_reg <= 1'b0;
    else
      q_reg <= q_next;
  end

  assign o_q = q_reg;
endmodule : piv_req_latch

`default_nettype wire

// *** src/piv_prio_enc.sv ***
`include "piv_consts.svh"
`default_nettype none

// ----------------------------------------------------------------------
// Eight-level priority encoder, input 0 is the highest
// ----------------------------------------------------------------------
module piv_prio_enc (
  input  wire logic [7:0] i_req,
  output logic [2:0]      o_level,
  output logic            o_any
);
  // Scan from the lowest priority upward so the last hit is the highest.
  // Input 0 (first timer) wins over all, input 7 loses to all. [R12]
  always_comb
  begin
    o_level = `PIV_IDLE_LEVEL;
    for (int i = 7; i >= 0; i--)
    begin
      if (i_req[i])
        o_level = 3'(i);
    end
    o_any = |i_req;
  end
endmodule : piv_prio_enc

`default_nettype wire

// *** src/piv_top.sv ***
`include "piv_consts.svh"
`default_nettype none

module piv_top (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire piv_pkg::piv_bus_t i_bus,
  input  wire piv_pkg::piv_src_t i_src,
  output logic [7:0]            o_din,
  output logic                  o_din_oe,
  output logic                  o_int
);
  import piv_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic       wr_q_reg;
  logic       wr_q_next;
  logic       vec_q_reg;
  logic       vec_q_next;
  logic [7:0] din_reg;
  logic [7:0] din_next;
  logic       oe_reg;
  logic       oe_next;
  logic       int_reg;
  logic       int_next;
  logic [7:0] latch;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] masked;
  logic [2:0] level;
  logic       pending;
  logic       wr_cond;
  logic       wr_edge;
  logic       rd_vec;
  logic       rd_sts;
  logic       ack_cond;
  logic       vec_edge;
  logic       ctl_rst;
  logic [7:0] vector;
  logic [7:0] status;

  // ----------------------------------------------------------------------
  // Request sources and latches
  // ----------------------------------------------------------------------
  // Source bits follow the mask order, first timer in bit 0. [R1] [R13]
  // The eighth input is chosen by the select command bit. [R2] [R3]
  always_comb
  begin
    set_vec[0] = i_src.timer_zero[0];
    set_vec[1] = i_src.timer_zero[1];
    set_vec[2] = i_src.ext_req;
    set_vec[3] = i_src.timer_zero[2];
    set_vec[4] = i_src.receive_ready;
    set_vec[5] = i_src.transmit_empty;
    set_vec[6] = i_src.timer_zero[3];
    set_vec[7] = cmd_reg[`PIV_CMD_SEL_BIT] ? i_src.timer_zero[4]
                                           : i_src.parallel_input_bit7;
    // Controller reset leaves transmit-empty requesting. [R5]
    if (ctl_rst)
      set_vec = set_vec | `PIV_TX_ONLY;
  end

  // Reset clears every bit at once; a vector hand-out clears only the
  // encoded bit, and only if that source is really requesting. [R4] [R6]
  // The same clear follows an acknowledge hand-out. [R7]
  always_comb
  begin
    clr_vec = 8'h00;
    if (vec_edge && masked[level])
      clr_vec[level] = 1'b1;
    if (ctl_rst)
      clr_vec = 8'hff;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_latch
      piv_req_latch u_latch (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (set_vec[g]),
        .i_clr      (clr_vec[g]),
        .o_q        (latch[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Masking, priority and vector
  // ----------------------------------------------------------------------
  // A zero mask bit only hides a request; the latch keeps it. [R9] [R10]
  assign masked  = latch & mask_reg;

  piv_prio_enc u_enc (
    .i_req   (masked),
    .o_level (level),
    .o_any   (pending)
  );

  // Restart opcode: level in bits 5..3, the rest ones. [R14] [R15] [R16]
  assign vector = {`PIV_VEC_HI, level, `PIV_VEC_LO};

  // Status shows raw serial latches and the pending flag. [R8] [R11]
  always_comb
  begin
    status = 8'h00;
    status[`PIV_STS_RX_BIT]   = latch[`PIV_SRC_RX];
    status[`PIV_STS_TX_BIT]   = latch[`PIV_SRC_TX];
    status[`PIV_STS_PEND_BIT] = pending;
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Strobes may stay asserted for many clocks, so each write, vector read or acknowledge acts once
  // on its first cycle; the latch is never cleared twice per read.
  assign wr_cond  = i_bus.s_out && !i_bus.p_wr_n;
  assign wr_edge  = wr_cond && !wr_q_reg;
  assign rd_vec   = (i_bus.addr == `PIV_PORT_VECTOR) && i_bus.s_inp &&
                    i_bus.p_dbin;                              // [R17]
  assign rd_sts   = (i_bus.addr[7:0] == `PIV_PORT_STATUS) && i_bus.s_inp &&
                    i_bus.p_dbin;
  assign ack_cond = i_bus.s_inta && cmd_reg[`PIV_CMD_ACK_BIT]; // [R18]
  assign vec_edge = (rd_vec || ack_cond) && !vec_q_reg;
  assign ctl_rst  = cmd_reg[`PIV_CMD_RESET_BIT];

  // ----------------------------------------------------------------------
  // Register and output next state
  // ----------------------------------------------------------------------
  // The reset bit lives one cycle, which is all the reset work needs. [R5]
  always_comb
  begin
    cmd_next   = cmd_reg;
    cmd_next[`PIV_CMD_RESET_BIT] = 1'b0;
    mask_next  = mask_reg;
    wr_q_next  = wr_cond;
    vec_q_next = rd_vec || ack_cond;
    din_next   = din_reg;
    oe_next    = rd_vec || ack_cond || rd_sts;
    int_next   = pending;                          // [R11] [R19]
    if (wr_edge)
    begin
      if (i_bus.addr[7:0] == `PIV_PORT_COMMAND)
        cmd_next = i_bus.dout;
      else if (i_bus.addr[7:0] == `PIV_PORT_MASK)
        mask_next = i_bus.dout;
    end
    // The vector is frozen at the first cycle, before its latch clears,
    // so the byte on the bus names the source that was serviced.
    if (vec_edge)
      din_next = vector;                           // [R7]
    else if (rd_sts)
      din_next = status;                           // [R8]
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmd_reg   <= `PIV_CMD_RESET_VAL;
      mask_reg  <= `PIV_MASK_RESET_VAL;
      wr_q_reg  <= 1'b0;
      vec_q_reg <= 1'b0;
      din_reg   <= 8'h00;
      oe_reg    <= 1'b0;
      int_reg   <= 1'b0;
    end
    else
    begin
      cmd_reg   <= cmd_next;
      mask_reg  <= mask_next;
      wr_q_reg  <= wr_q_next;
      vec_q_reg <= vec_q_next;
      din_reg   <= din_next;
      oe_reg    <= oe_next;
      int_reg   <= int_next;
    end
  end

  assign o_din    = din_reg;
  assign o_din_oe = oe_reg;
  assign o_int    = int_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_vector_clear: assert property ( // [R6]
    vec_edge && masked[level] && !set_vec[level] && !ctl_rst
      |=> !latch[$past(level)])
    else $error("Serviced request was not cleared.");

  chk_vector_byte: assert property ( // [R16]
    vec_edge |=> o_din == {2'h3, $past(level), 3'h7})
    else $error("Vector byte malformed.");

  chk_pending_pin: assert property ( // [R11]
    ##1 o_int == $past(|(latch & mask_reg)))
    else $error("Interrupt pin does not follow masked requests.");

  chk_ack_ignored: assert property ( // [R18]
    i_bus.s_inta && !cmd_reg[3] && !rd_vec && !rd_sts |=> !o_din_oe)
    else $error("Acknowledge answered while disabled.");

  chk_reset_clears: assert property ( // [R4]
    ctl_rst |=> latch == ($past(set_vec) | 8'h20))
    else $error("Controller reset left stale requests.");

  chk_reset_self: assert property ( // [R5]
    ctl_rst && !wr_edge |=> !ctl_rst)
    else $error("Reset bit did not clear itself.");

  chk_idle_level: assert property ( // [R15]
    masked == 8'h00 |-> level == 3'h7 && !pending)
    else $error("Idle encoder not at lowest level.");

  chk_top_priority: assert property ( // [R12]
    masked[0] |-> level == 3'h0)
    else $error("First timer not highest priority.");

  chk_eighth_source: assert property ( // [R3]
    !cmd_reg[2] && i_src.parallel_input_bit7 |=> latch[7])
    else $error("Parallel bit seven did not latch.");

  chk_read_drivers: assert property ( // [R17]
    rd_vec |=> o_din_oe)
    else $error("Vector read did not enable drivers.");

  chk_ack_drivers: assert property ( // [R18]
    ack_cond |=> o_din_oe)
    else $error("Enabled acknowledge did not drive the bus.");

  // Only a decoded read or an enabled acknowledge may turn drivers on.
  chk_idle_drivers: assert property ( // [R17]
    !rd_vec && !rd_sts && !ack_cond |=> !o_din_oe)
    else $error("Drivers enabled without a decoded read.");

  // Status reads show the raw serial latches, whatever the mask says.
  chk_status_raw: assert property ( // [R8]
    rd_sts && !vec_edge |=>
      o_din[`PIV_STS_TX_BIT] == $past(latch[`PIV_SRC_TX]) &&
      o_din[`PIV_STS_RX_BIT] == $past(latch[`PIV_SRC_RX]) &&
      o_din[`PIV_STS_PEND_BIT] == $past(pending))
    else $error("Status byte does not show the latches.");

  // An acknowledge hand-out clears its request just as a port read does.
  chk_ack_clear: assert property ( // [R7]
    ack_cond && !vec_q_reg && masked[level] && !set_vec[level] &&
      !ctl_rst |=> !latch[$past(level)])
    else $error("Acknowledged request was not cleared.");

  // The pin may only drop once no unmasked request is left.
  chk_pending_clear: assert property ( // [R19]
    $fell(o_int) |-> $past((latch & mask_reg) == 8'h00))
    else $error("Pending dropped while a request was left.");

  chk_tx_survives: assert property ( // [R5]
    ctl_rst |=> latch[`PIV_SRC_TX])
    else $error("Controller reset dropped transmit-empty.");

  // No latch bit rises without its own source, outside a reset.
  chk_source_own: assert property ( // [R1]
    !ctl_rst |=> (latch & ~$past(latch) & ~$past(set_vec)) == 8'h00)
    else $error("A latch bit set without its own source.");

  // A masked-off request must wait in its latch, not be lost.
  chk_mask_retains: assert property ( // [R10]
    !ctl_rst |=> ($past(latch & ~mask_reg) & ~latch) == 8'h00)
    else $error("Masked request dropped from its latch.");

  // No enabled request may sit above the one the encoder names.
  chk_encoded_level: assert property ( // [R13]
    masked != 8'h00 |->
      masked[level] && (masked & ((8'h01 << level) - 8'h01)) == 8'h00)
    else $error("Encoder did not pick the highest request.");

  chk_eighth_timer: assert property ( // [R2]
    cmd_reg[`PIV_CMD_SEL_BIT] && i_src.timer_zero[4] |=> latch[7])
    else $error("Fifth timer did not reach the eighth latch.");

  chk_mask_gate: assert property ( // [R9]
    (latch & mask_reg) == 8'h00 |=> !o_int)
    else $error("Interrupt raised with every request masked.");

  // ----------------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------------
  cov_vector_read: cover property (rd_vec && !vec_q_reg && pending);
  cov_ack_cycle:   cover property (ack_cond && !vec_q_reg && pending);
  cov_ctl_reset:   cover property (ctl_rst ##1 latch == 8'h20);
  cov_masked_hold: cover property (latch != 8'h00 && masked == 8'h00);
  cov_eighth_timer: cover property (cmd_reg[`PIV_CMD_SEL_BIT] &&
                                    i_src.timer_zero[4]);
endmodule : piv_top

`default_nettype wire

// *** test/piv_host.sv ***
`default_nettype none

// ----------------------------------------------------------------
// Host processor model driving the bus cycles
// ----------------------------------------------------------------
module piv_host (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic [7:0]   i_din,
  input  wire logic         i_din_oe,
  output piv_pkg::piv_bus_t o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  import piv_pkg::*;

  logic [7:0]  page_reg;
  logic [15:0] call_addr;

  // Idle bus: no strobe, write strobe inactive high.
  initial
  begin
    o_bus = '{p_wr_n: 1'b1, default: '0};
  end

  // Table page goes to zero on every reset; clocked so that a reset
  // already low at time zero is not missed.
  always @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      page_reg <= 8'h00;

  // Kind 0 writes, 1 reads a port, 2 is an acknowledge cycle.
  task automatic cyc(input int k, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic oe);
    // A cycle starts only once the one before has ended; a held or
    // not-ready bus would simply stretch this wait.
    @(negedge i_core_clk);
    o_bus.addr = a;
    o_bus.dout = d;
    o_bus.s_out = (k == 0);
    o_bus.p_wr_n = (k != 0);
    o_bus.s_inp = (k == 1);
    o_bus.s_inta = (k == 2);
    o_bus.p_dbin = (k != 0);
    repeat ((k == 0) ? 1 : 2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    q = i_din;
    oe = i_din_oe;
    // Released lines flip so a stale value never looks valid.
    o_bus.addr = ~a;
    o_bus.dout = ~d;
    o_bus.s_out = 1'b0;
    o_bus.p_wr_n = 1'b1;
    o_bus.s_inp = 1'b0;
    o_bus.s_inta = 1'b0;
    o_bus.p_dbin = 1'b0;
    // Pointer byte fetched after acknowledge, bit zero forced low.
    if (k == 2 && oe) call_addr = {page_reg, q[7:1], 1'b0};
    @(negedge i_core_clk);
  endtask : cyc

  // Fixed-call entry issues no acknowledge; the vector is polled.
  task automatic fixed_call(output logic [7:0] q, output logic oe);
    call_addr = 16'h0038;
    cyc(1, 16'h0303, 8'h00, q, oe);
  endtask : fixed_call
endmodule : piv_host

`default_nettype wire

// *** test/prioritized_interrupt_vectoring_tb.sv ***
`default_nettype none

module prioritized_interrupt_vectoring_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import piv_pkg::*;

  logic       i_core_clk;
  logic       i_rst_n;
  piv_bus_t   bus;
  piv_src_t   src;
  logic [7:0] din;
  logic       din_oe;
  logic       int_o;
  int         err_total;
  int         num_checks;
  int         seed;
  int         i;
  logic [31:0] r;
  logic [7:0] lat;
  logic [7:0] msk;
  logic [7:0] m;
  logic [7:0] e;
  logic [7:0] q;
  logic       sel;
  logic       ack_en;
  logic       oe;

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  piv_top u_dut (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_bus      (bus),
    .i_src      (src),
    .o_din      (din),
    .o_din_oe   (din_oe),
    .o_int      (int_o)
  );

  piv_host u_host (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_din      (din),
    .i_din_oe   (din_oe),
    .o_bus      (bus)
  );

  // ----------------------------------------------------------------
  // Reference model helpers
  // ----------------------------------------------------------------
  // Lowest set bit wins, so the loop runs from level 7 down.
  function automatic logic [7:0] vec(input logic [7:0] v);
    vec = 8'hff;
    for (int k = 7; k >= 0; k--)
      if (v[k]) vec = 8'hc7 | 8'(k << 3);
  endfunction : vec

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Run takes about 2700 cycles; the watchdog allows many more.
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Random traffic against the model
  // ----------------------------------------------------------------
  initial
  begin
    seed = 16;
    err_total = 0;
    num_checks = 0;
    i_rst_n = 1'b0;
    src = '0;
    {lat, msk, sel, ack_en} = '0;
    repeat (20) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    for (i = 0; i < 400; i++)
    begin
      r = $random(seed);
      @(negedge i_core_clk);
      src = piv_src_t'(r[8:0] & r[17:9]);
      lat = lat | {sel ? src.timer_zero[4] : src.parallel_input_bit7,
                   src.timer_zero[3], src.transmit_empty,
                   src.receive_ready, src.timer_zero[2], src.ext_req,
                   src.timer_zero[1], src.timer_zero[0]};
      @(negedge i_core_clk);
      src = '0;
      m = lat & msk;
      e = vec(m);
      case (r[20:18])
        3'd0, 3'd1:
        begin
          if (r[18]) u_host.fixed_call(q, oe);
          else u_host.cyc(1, 16'h0303, 8'h00, q, oe);
          chk({7'h00, oe}, 8'h01);
          chk(q, e);
          lat = lat & ~(m & (~m + 8'h01));
        end
        3'd2:
        begin
          u_host.cyc(1, {r[31:24], 8'h00}, 8'h00, q, oe);
          chk(q, {lat[5], lat[4], 5'h00, |m});
        end
        3'd3:
        begin
          u_host.cyc(2, 16'h0000, 8'h00, q, oe);
          chk({7'h00, oe}, {7'h00, ack_en});
          if (ack_en) chk(q, e);
          if (ack_en) chk(u_host.call_addr[7:0], {e[7:1], 1'b0});
          if (ack_en) lat = lat & ~(m & (~m + 8'h01));
        end
        3'd4:
        begin
          msk = r[31:24];
          u_host.cyc(0, {r[15:8], 8'h03}, msk, q, oe);
        end
        3'd5:
        begin
          ack_en = r[21];
          sel = r[22];
          u_host.cyc(0, 16'h0002, {4'h0, ack_en, sel, 1'b0, r[23] & r[24]},
                     q, oe);
          if (r[23] & r[24]) lat = 8'h20;
        end
        default:
        begin
          u_host.cyc(1, 16'h0403, 8'h00, q, oe);
          chk({7'h00, oe}, 8'h00);
        end
      endcase
      @(negedge i_core_clk);
      chk({7'h00, int_o}, {7'h00, |(lat & msk)});
    end
    end_of_test();
  end
endmodule : prioritized_interrupt_vectoring_tb

`default_nettype wire
